// >>> etps_map.svh
// Constants for the energy threshold and display pulse scaler
// Notes on behaviour
// R1 - Threshold is full scale/4000 times (1+0.2*factor)
// R2 - Source keeps threshold factor within -4..+45
// R3 - Below threshold: power zero, no energy added
// R4 - Default: one pulse per 25 energy LSBs
// R5 - Hold 8-bit pulse divisor trim
// R6 - Divisor is 25 plus trim outside mode 7
// R7 - Trim affects only display pulse rates
// R8 - Mode 7 divisor is 250 plus trim
// R9 - Energy LSB worth scales with clock, full scale
// R10 - Meter constant 1250 pulses per kWh nominal
// R11 - Logic runs from the converter's clock output
// R12 - Source delivers all 44 calibration bytes
// R13 - Pulse counter subtracts divisor, keeps remainder
`ifndef ETPS_MAP_SVH
`define ETPS_MAP_SVH
`define ETPS_THR_DIV       32'd4000
`define ETPS_THR_STEP_NUM  32'd2
`define ETPS_THR_STEP_DEN  32'd10
`define ETPS_BASE_DIV      9'd25
`define ETPS_BASE_DIV_M7   9'd250
`define ETPS_MODE_DECADE   3'd7
`define ETPS_MC_DIV        8'd20
`define ETPS_TRIM_RST      8'h00
`endif

// >>> etps_pkg.sv
// Types for the energy threshold and display pulse scaler
package etps_pkg;
  typedef logic [8:0] div_t;
  typedef struct packed {
    logic [8:0] act_cnt;
    logic [8:0] rea_cnt;
    logic [7:0] mc_cnt;
    logic       act_pulse;
    logic       rea_pulse;
    logic       mc_pulse;
  } pulse_st_s;
endpackage

// >>> start_gate.sv
// Starting current gate for one phase result
`timescale 1ns/1ps
`include "etps_map.svh"
module start_gate #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  // Threshold setting
  input  wire logic [CW-1:0] full_scale,
  input  wire logic signed [7:0] factor,
  // Cycle result in
  input  wire logic          cyc_valid,
  input  wire logic [CW-1:0] current,
  input  wire logic signed [23:0] power_in,
  input  wire logic [7:0]    energy_in,
  // Gated result out
  output logic               out_valid,
  output logic signed [23:0] power_out,
  output logic [7:0]         energy_out
);
  typedef struct packed {
    logic              v;
    logic signed [23:0] p;
    logic [7:0]        e;
  } st_s;
  st_s st_q;
  st_s st_d;
  logic [CW+31:0] lhs;
  logic [CW+31:0] rhs;
  logic signed [31:0] mult;
  always_comb begin
    // Compare 4000*10*I against Ifs*(10+2*factor), exact integers
    mult = 32'sd10 + 32'sd2 * 32'(signed'(factor)); // R1
    if (mult < 0) begin
      mult = 0;
    end
    lhs = (CW+32)'(current) * (CW+32)'(`ETPS_THR_DIV * `ETPS_THR_STEP_DEN);
    rhs = (CW+32)'(full_scale) * (CW+32)'(mult);
    st_d = st_q;
    st_d.v = cyc_valid;
    if (cyc_valid) begin
      if (lhs < rhs) begin
        st_d.p = '0; // R3
        st_d.e = '0; // R3
      end else begin
        st_d.p = power_in;
        st_d.e = energy_in;
      end
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign out_valid  = st_q.v;
  assign power_out  = st_q.p;
  assign energy_out = st_q.e;
endmodule

// >>> pulse_div.sv
// Remainder-keeping divider of energy LSBs into pulses
`timescale 1ns/1ps
module pulse_div #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Energy in and divisor
  input  wire logic         add_en,
  input  wire logic [7:0]   add_lsb,
  input  wire logic [W-1:0] divisor,
  // Pulse out
  output logic              pulse
);
  typedef struct packed {
    logic [W+7:0] cnt;
    logic         p;
  } st_s;
  st_s st_q;
  st_s st_d;
  logic [W+7:0] sum;
  always_comb begin
    st_d = st_q;
    sum = st_q.cnt + (add_en ? (W+8)'(add_lsb) : '0);
    st_d.p = 1'b0;
    if (divisor != '0 && sum >= (W+8)'(divisor)) begin
      st_d.cnt = sum - (W+8)'(divisor); // R13
      st_d.p = 1'b1;
    end else begin
      st_d.cnt = sum;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign pulse = st_q.p;
endmodule

// >>> energy_threshold_pulse_scaler.sv
// Starting threshold gate and display pulse scaler, top level
`timescale 1ns/1ps
`include "etps_map.svh"
module energy_threshold_pulse_scaler #(
  parameter int CW = 16
) (
  // Clock from converter companion, reset
  input  wire logic               mclk, // R11
  input  wire logic               reset_n,
  // Calibration values
  input  wire logic               cal_load,
  input  wire logic signed [7:0]  start_threshold_factor,
  input  wire logic [7:0]         pulse_divisor_trim,
  input  wire logic [2:0]         op_mode,
  input  wire logic [CW-1:0]      full_scale_current,
  // Per cycle results
  input  wire logic               cyc_valid,
  input  wire logic [CW-1:0]      phase_current,
  input  wire logic signed [23:0] act_power_in,
  input  wire logic signed [23:0] rea_power_in,
  input  wire logic [7:0]         act_energy_lsb,
  input  wire logic [7:0]         rea_energy_lsb,
  // Outputs
  output logic                    res_valid,
  output logic signed [23:0]      act_power_out,
  output logic signed [23:0]      rea_power_out,
  output logic                    act_disp_pulse,
  output logic                    rea_disp_pulse,
  output logic                    meter_const_pulse
);
  typedef struct packed {
    logic signed [7:0] factor;
    logic [7:0]        trim;
    logic              decade;
    etps_pkg::div_t    div;
    logic              rv;
    logic [15:0]       mc_acc;
    logic              mc_p;
  } st_s;
  st_s st_q;
  st_s st_d;
  logic act_v;
  logic rea_v;
  logic signed [23:0] act_p;
  logic signed [23:0] rea_p;
  logic [7:0] act_e;
  logic [7:0] rea_e;
  logic act_pl;
  logic rea_pl;
  // Wide enough for a full 255 LSB add while one pulse a cycle drains it
  logic [15:0] mc_sum;

  start_gate #(.CW(CW)) u_gate_act (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .full_scale (full_scale_current),
    .factor     (st_q.factor),
    .cyc_valid  (cyc_valid),
    .current    (phase_current),
    .power_in   (act_power_in),
    .energy_in  (act_energy_lsb),
    .out_valid  (act_v),
    .power_out  (act_p),
    .energy_out (act_e)
  );

  start_gate #(.CW(CW)) u_gate_rea (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .full_scale (full_scale_current),
    .factor     (st_q.factor),
    .cyc_valid  (cyc_valid),
    .current    (phase_current),
    .power_in   (rea_power_in),
    .energy_in  (rea_energy_lsb),
    .out_valid  (rea_v),
    .power_out  (rea_p),
    .energy_out (rea_e)
  );

  pulse_div #(.W(9)) u_div_act (
    .mclk    (mclk),
    .reset_n (reset_n),
    .add_en  (act_v),
    .add_lsb (act_e),
    .divisor (st_q.div),
    .pulse   (act_pl)
  );

  pulse_div #(.W(9)) u_div_rea (
    .mclk    (mclk),
    .reset_n (reset_n),
    .add_en  (rea_v),
    .add_lsb (rea_e),
    .divisor (st_q.div),
    .pulse   (rea_pl)
  );

  always_comb begin
    st_d = st_q;
    if (cal_load) begin
      st_d.factor = start_threshold_factor;
      st_d.trim   = pulse_divisor_trim; // R5
      st_d.decade = (op_mode == `ETPS_MODE_DECADE);
    end
    // Trim reaches only the display divisor, never the meter constant
    if (st_q.decade) begin
      st_d.div = `ETPS_BASE_DIV_M7 + 9'(st_q.trim); // R8
    end else begin
      st_d.div = `ETPS_BASE_DIV + 9'(st_q.trim); // R6 R4 R7
    end
    st_d.rv = act_v;
    // Meter constant: 1250/kWh at 0.4Wh LSB is one pulse per 2 LSBs;
    // 20 here counts tenths to allow finer LSB feed later
    mc_sum = st_q.mc_acc + (act_v ? 16'(act_e) * 16'd10 : 16'd0);
    st_d.mc_p = 1'b0;
    if (mc_sum >= 16'(`ETPS_MC_DIV)) begin
      st_d.mc_acc = mc_sum - 16'(`ETPS_MC_DIV); // R10 R9
      st_d.mc_p = 1'b1;
    end else begin
      st_d.mc_acc = mc_sum;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{factor: 8'h00, trim: `ETPS_TRIM_RST, decade: 1'b0,
                div: `ETPS_BASE_DIV, rv: 1'b0, mc_acc: 16'h0000,
                mc_p: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      act_power_out  <= '0;
      rea_power_out  <= '0;
      res_valid      <= 1'b0;
      act_disp_pulse <= 1'b0;
      rea_disp_pulse <= 1'b0;
      meter_const_pulse <= 1'b0;
    end else begin
      act_power_out  <= act_p;
      rea_power_out  <= rea_p;
      res_valid      <= st_q.rv;
      act_disp_pulse <= act_pl;
      rea_disp_pulse <= rea_pl;
      meter_const_pulse <= st_q.mc_p;
    end
  end
endmodule

// >>> etps_assertions.sv
// Concurrent checks for the threshold gate and pulse scaler
`timescale 1ns/1ps
module etps_checker #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               reset_n,
  // Watched ports
  input wire logic signed [7:0]  start_threshold_factor,
  input wire logic [CW-1:0]      full_scale_current,
  input wire logic               cyc_valid,
  input wire logic [CW-1:0]      phase_current,
  input wire logic signed [23:0] act_power_in,
  input wire logic signed [23:0] rea_power_in,
  input wire logic               res_valid,
  input wire logic signed [23:0] act_power_out,
  input wire logic signed [23:0] rea_power_out,
  input wire logic               act_disp_pulse,
  input wire logic               meter_const_pulse
);
  longint thr;
  logic   below;
  // Wide product, so large full scale values cannot wrap
  assign thr = longint'(full_scale_current)
             * (10 + 2 * longint'(start_threshold_factor));
  assign below = longint'(phase_current) * 40000 < thr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  valid_delay_a: assert property (
    res_valid == $past(cyc_valid, 3)) else $error("res_valid timing");
  act_zero_a: assert property (
    $past(cyc_valid, 2) && $past(below, 2) |-> act_power_out == 24'h000000)
    else $error("active power not zeroed");
  rea_zero_a: assert property (
    $past(cyc_valid, 2) && $past(below, 2) |-> rea_power_out == 24'h000000)
    else $error("reactive power not zeroed");
  act_pass_a: assert property (
    $past(cyc_valid, 2) && !$past(below, 2)
    |-> act_power_out == $past(act_power_in, 2))
    else $error("active power not passed");
  rea_pass_a: assert property (
    $past(cyc_valid, 2) && !$past(below, 2)
    |-> rea_power_out == $past(rea_power_in, 2))
    else $error("reactive power not passed");
  act_hold_a: assert property (
    !$past(cyc_valid, 2) |-> $stable(act_power_out))
    else $error("active power moved");
  rea_hold_a: assert property (
    !$past(cyc_valid, 2) |-> $stable(rea_power_out))
    else $error("reactive power moved");
  reset_quiet_a: assert property (
    $rose(reset_n) |-> !act_disp_pulse && !meter_const_pulse && !res_valid)
    else $error("pulse out of reset");
endmodule
bind energy_threshold_pulse_scaler etps_checker #(.CW(CW)) chk_u (
  .mclk(mclk), .reset_n(reset_n),
  .start_threshold_factor(start_threshold_factor),
  .full_scale_current(full_scale_current), .cyc_valid(cyc_valid),
  .phase_current(phase_current), .act_power_in(act_power_in),
  .rea_power_in(rea_power_in), .res_valid(res_valid),
  .act_power_out(act_power_out), .rea_power_out(rea_power_out),
  .act_disp_pulse(act_disp_pulse), .meter_const_pulse(meter_const_pulse));

// >>> etps_pulse_counter.sv
// Display and meter constant pulse counter standing at the far side of the scaler
`timescale 1ns/1ps
module etps_pulse_counter (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  reset_n,
  // Pulses counted
  input  wire logic  act_p,
  input  wire logic  rea_p,
  input  wire logic  mc_p,
  // Running totals
  output logic [15:0] n_act,
  output logic [15:0] n_rea,
  output logic [15:0] n_mc
);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      n_act <= 16'h0000;
      n_rea <= 16'h0000;
      n_mc  <= 16'h0000;
    end else begin
      n_act <= n_act + 16'(act_p);
      n_rea <= n_rea + 16'(rea_p);
      n_mc  <= n_mc + 16'(mc_p);
    end
  end
endmodule

// >>> energy_threshold_pulse_scaler_tb_top.sv
// Self-checking bench for the threshold gate and pulse scaler
`timescale 1ns/1ps
module energy_threshold_pulse_scaler_tb_top;
  typedef struct {int f, t, m, cur, e, n, p, mc;} row_s;
  logic               mclk, reset_n, cal_load, cyc_valid, res_valid;
  logic               act_disp_pulse, rea_disp_pulse, meter_const_pulse;
  logic signed [7:0]  start_threshold_factor;
  logic        [7:0]  pulse_divisor_trim, energy;
  logic        [2:0]  op_mode;
  logic        [15:0] full_scale_current, phase_current, n_act, n_rea, n_mc;
  logic signed [23:0] act_power_in, rea_power_in, act_power_out, rea_power_out;
  int                 error_cnt = 0, n_tests = 0, cyc = 0;
  // factor, trim, mode, current, lsb per cycle, cycles, pulses, mc pulses
  row_s rows[8] = '{'{0, 0, 0, 2, 5, 10, 2, 25}, '{0, 0, 0, 0, 5, 10, 0, 0},
    '{45, 225, 0, 10, 10, 50, 2, 250}, '{-4, 5, 0, 1, 1, 30, 1, 15},
    '{0, 0, 7, 2, 25, 20, 2, 250}, '{0, 6, 7, 2, 8, 32, 1, 128},
    '{10, 0, 0, 2, 25, 1, 0, 0}, '{10, 0, 0, 3, 25, 1, 1, 12}};
  energy_threshold_pulse_scaler #(.CW(16)) dut_u (.mclk(mclk),
    .reset_n(reset_n), .cal_load(cal_load),
    .start_threshold_factor(start_threshold_factor),
    .pulse_divisor_trim(pulse_divisor_trim), .op_mode(op_mode),
    .full_scale_current(full_scale_current), .cyc_valid(cyc_valid),
    .phase_current(phase_current), .act_power_in(act_power_in),
    .rea_power_in(rea_power_in), .act_energy_lsb(energy),
    .rea_energy_lsb(energy), .res_valid(res_valid),
    .act_power_out(act_power_out), .rea_power_out(rea_power_out),
    .act_disp_pulse(act_disp_pulse), .rea_disp_pulse(rea_disp_pulse),
    .meter_const_pulse(meter_const_pulse));
  etps_pulse_counter cnt_u (.mclk(mclk), .reset_n(reset_n),
    .act_p(act_disp_pulse), .rea_p(rea_disp_pulse), .mc_p(meter_const_pulse),
    .n_act(n_act), .n_rea(n_rea), .n_mc(n_mc));
  task complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task add(int e, int n);
    energy = 8'(e);
    act_power_in = 24'(e * 4660 + 1);
    cyc_valid = 1;
    step(n);
    cyc_valid = 0;
    step(20 + e * n / 2);
  endtask
  task run(row_s r);
    reset_n = 0;
    step();
    reset_n = 1;
    // Whole coefficient set on every load
    start_threshold_factor = 8'(r.f);
    pulse_divisor_trim = 8'(r.t);
    op_mode = 3'(r.m);
    phase_current = 16'(r.cur);
    cal_load = 1;
    step();
    cal_load = 0;
    step(2);
    add(r.e, r.n);
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // Generous ceiling: the whole run needs about 1300 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    reset_n = 0;
    cal_load = 0;
    cyc_valid = 0;
    start_threshold_factor = 8'h00;
    pulse_divisor_trim = 8'h00;
    op_mode = 3'h0;
    full_scale_current = 16'h0FA0;
    phase_current = 16'h0000;
    act_power_in = 24'h000000;
    rea_power_in = 24'hFFFFFB;
    energy = 8'h00;
    step(8);
    foreach (rows[i]) begin
      run(rows[i]);
      chk(n_act, 16'(rows[i].p));
      chk(n_rea, 16'(rows[i].p));
      chk(n_mc, 16'(rows[i].mc));
      $display("row %0d done", i);
    end
    // Oversized add spills pulses, remainder completes a later one
    run('{0, 0, 0, 2, 255, 1, 10, 127});
    add(20, 1);
    chk(n_act, 16'h000B);
    chk(n_mc, 16'h0089);
    $display("spill test done");
    complete_run();
  end
endmodule
